// File: bench/plsr_receiver.sv
`timescale 1ns/1ps
// Stalls two cycles in four so the buffer holds bits
module plsr_receiver (
  input wire logic ref_clk,
  output logic out_ready
);
  logic [1:0] ph_ff = 2'h0;
  initial out_ready = 1'b0;
  always @(negedge ref_clk) begin
    ph_ff <= ph_ff + 2'h1;
    out_ready <= ph_ff[1];
  end
endmodule : plsr_receiver

// File: bench/tb_parallel_load_shift_register.sv
`timescale 1ns/1ps
module tb_parallel_load_shift_register;
  import plsr_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, sck = 1'b0, inh = 1'b0;
  logic sin = 1'b0, rdy, vld, ob, so, so_n, sv, e;
  logic [PLSR_WIDTH-1:0] pin = 8'h00, m;
  logic exp_q[$];
  int n_errors = 0, total_checks = 0;
  plsr_shift_register uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .shift_load_select(sel), .shift_clock(sck), .clock_inhibit(inh),
    .serial_in(sin), .parallel_in(pin), .out_ready(rdy), .out_valid(vld),
    .out_bit(ob), .serial_out(so), .serial_out_n(so_n), .stages_valid(sv));
  plsr_receiver rx (.ref_clk(ref_clk), .out_ready(rdy));
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // A pop with nothing noted compares against x and fails
  always @(posedge ref_clk) if (vld === 1'b1 && rdy === 1'b1) begin
    e = exp_q.size() > 0 ? exp_q.pop_front() : 1'bx;
    chk(ob, e);
    chk(so_n, ~so);
  end
  initial begin
    #20000;
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(16));
    cyc(8);
    chk(sv, 1'b0);
    rst_n = 1'b1;
    for (int r = 0; r < 4; r++) begin
      if (r == 2) begin
        rst_n = 1'b0; // Mid-run reset drops the loaded mark
        cyc(2);
        chk(sv, 1'b0);
        rst_n = 1'b1;
      end
      pin = 8'($urandom);
      sel = 1'b0;
      cyc(5);
      chk(so, pin[7]);
      chk(sv, 1'b1);
      pin = ~pin;
      cyc(5);
      m = pin;
      chk(so_n, ~pin[7]);
      sel = 1'b1;
      cyc(5);
      pin = 8'($urandom);
      cyc(5);
      chk(so, m[7]);
      for (int b = 0; b < 8; b++) begin
        sin = 1'($urandom);
        exp_q.push_back(m[7]); // Bit leaving the last stage
        m = {m[6:0], sin};
        if (b[0]) begin
          inh = 1'b1;
          cyc(5);
          sck = 1'b1; // Blocked edge, no extra pop
          cyc(5);
          sck = 1'b0;
        end else sck = 1'b1;
        cyc(5);
        inh = 1'b0;
        sck = 1'b0;
        cyc(5);
        chk(so, m[7]);
      end
    end
    cyc(10);
    chk(exp_q.size() == 0, 1'b1);
    results();
  end
endmodule : tb_parallel_load_shift_register

// File: hdl/plsr_pkg.sv
package plsr_pkg;
  localparam int PLSR_WIDTH = 8;
  localparam int PLSR_BUF_DEPTH = 2;
  localparam int PLSR_SYNC_STAGES = 2;
  localparam logic [1:0] PLSR_MODE_LOAD = 2'h0;
  localparam logic [1:0] PLSR_MODE_SHIFT = 2'h1;
endpackage : plsr_pkg

// File: hdl/plsr_shift_register.sv
`timescale 1ns/1ps
// Operation
// - Two modes, parallel load and serial shift, picked by the select level.
// - While select is low every stage takes its matching parallel input.
// - The load follows the inputs for as long as select stays low.
// - During load the true output shows the last input, the other its inverse.
// - With select high and no effective clock rise, all stages hold.
// - On an effective rise in shift mode, with the buffer not full, the first stage takes serial in.
// - On an effective rise in shift mode, with the buffer not full, each stage moves one place toward the output.
// - The true output follows the last stage and the inverted one its inverse.
// - Clock edges are ignored while inhibit is high.
// - Clock and inhibit are interchangeable; the effective clock is their OR.
// - Shift on clock rise with inhibit low or inhibit rise with clock low.
// - Stages have no defined value until the first parallel load.
module plsr_shift_register #(
  parameter int WIDTH = plsr_pkg::PLSR_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic shift_load_select,
  input wire logic shift_clock,
  input wire logic clock_inhibit,
  input wire logic serial_in,
  input wire logic [WIDTH-1:0] parallel_in,
  input wire logic out_ready,
  output logic out_valid,
  output logic out_bit,
  output logic serial_out,
  output logic serial_out_n,
  output logic stages_valid
);
  import plsr_pkg::*;

  // One-bit pointers and two sync flops; nothing else is served
  localparam bit cfg_bad = (WIDTH < 2) || (PLSR_BUF_DEPTH != 2)
    || (PLSR_SYNC_STAGES != 2);
  if (cfg_bad) begin : g_cfg_check
    $error("Unsupported width, buffer depth or sync length");
  end

  // Pins are asynchronous to ref_clk
  logic [PLSR_SYNC_STAGES-1:0] sel_sy_ff, clk_sy_ff, inh_sy_ff, ser_sy_ff;
  logic [WIDTH-1:0] par_s1_ff, par_s2_ff;
  logic eff_clk_prev_ff;
  logic [WIDTH-1:0] stage_ff, nxt_stage;
  logic loaded_ff, nxt_loaded;
  logic [0:0] buf_mem [PLSR_BUF_DEPTH];
  logic buf_wp_ff, buf_rp_ff;
  logic [1:0] buf_cnt_ff;

  always_ff @(posedge ref_clk) begin
    sel_sy_ff <= {sel_sy_ff[0], shift_load_select};
    clk_sy_ff <= {clk_sy_ff[0], shift_clock};
    inh_sy_ff <= {inh_sy_ff[0], clock_inhibit};
    ser_sy_ff <= {ser_sy_ff[0], serial_in};
    par_s1_ff <= parallel_in;
    par_s2_ff <= par_s1_ff;
  end

  wire sel_s = sel_sy_ff[1];
  wire ser_s = ser_sy_ff[1];
  wire [1:0] mode = sel_s ? PLSR_MODE_SHIFT : PLSR_MODE_LOAD;
  wire eff_clk = clk_sy_ff[1] | inh_sy_ff[1];
  wire eff_rise = eff_clk & ~eff_clk_prev_ff;
  wire buf_full = (buf_cnt_ff == 2'(PLSR_BUF_DEPTH));
  wire buf_empty = (buf_cnt_ff == 2'h0);
  wire shift_go = (mode == PLSR_MODE_SHIFT) && eff_rise && !buf_full;
  wire buf_push = shift_go;
  wire buf_pop = out_valid && out_ready;

  // One place toward the output, serial bit into the first stage
  function automatic logic [WIDTH-1:0] shift_one(
    input logic [WIDTH-1:0] cur,
    input logic ser
  );
    return {cur[WIDTH-2:0], ser};
  endfunction : shift_one

  // Edge lost only if the buffer is full; receiver must drain
  always_comb begin
    nxt_stage = stage_ff;
    nxt_loaded = loaded_ff;
    if (mode == PLSR_MODE_LOAD) begin
      nxt_stage = par_s2_ff;
      nxt_loaded = 1'b1;
    end else if (shift_go) begin
      nxt_stage = shift_one(stage_ff, ser_s);
    end
  end

  always_ff @(posedge ref_clk) begin
    eff_clk_prev_ff <= eff_clk;
    stage_ff <= nxt_stage; // no reset on the data path
    if (!rst_n) begin
      loaded_ff <= 1'b0;
    end else begin
      loaded_ff <= nxt_loaded;
    end
  end

  // Two-entry buffer of bits leaving the last stage
  always_ff @(posedge ref_clk) begin
    if (buf_push) begin
      buf_mem[buf_wp_ff] <= stage_ff[WIDTH-1];
    end
    if (!rst_n) begin
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (buf_push) buf_wp_ff <= ~buf_wp_ff;
      if (buf_pop) buf_rp_ff <= ~buf_rp_ff;
      buf_cnt_ff <= buf_cnt_ff + 2'(buf_push) - 2'(buf_pop);
    end
  end

  assign out_valid = !buf_empty;
  assign serial_out = stage_ff[WIDTH-1];
  assign serial_out_n = ~stage_ff[WIDTH-1];
  assign stages_valid = loaded_ff;

  // Head of the buffer; a mux of flops with no logic behind it
  assign out_bit = buf_mem[buf_rp_ff];

  // Steps of a load, of shift readiness and of the two kinds of effective rise
  sequence s_load_held;
    !sel_s [*2];
  endsequence

  sequence s_shift_ready;
    sel_s && !buf_full && loaded_ff;
  endsequence

  sequence s_clk_rise;
    clk_sy_ff[1] && !inh_sy_ff[1]
      && !$past(clk_sy_ff[1]) && !$past(inh_sy_ff[1]);
  endsequence

  sequence s_inh_rise;
    inh_sy_ff[1] && !clk_sy_ff[1]
      && !$past(inh_sy_ff[1]) && !$past(clk_sy_ff[1]);
  endsequence

  chk_load_follows: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_load_held |-> stage_ff == $past(par_s2_ff))
    else $error("Stages do not follow parallel inputs");

  chk_load_output: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !sel_s |=> serial_out == $past(par_s2_ff[WIDTH-1]))
    else $error("Serial output not last parallel input in load");

  chk_load_inverse: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !sel_s |=> serial_out_n == !$past(par_s2_ff[WIDTH-1]))
    else $error("Inverted output not complement in load");

  chk_hold_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sel_s && !eff_rise && loaded_ff |=> $stable(stage_ff))
    else $error("Stages changed without clock edge");

  chk_shift_in: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shift_go |=> stage_ff[0] == $past(ser_s))
    else $error("First stage missed serial input");

  chk_shift_move: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shift_go && loaded_ff
      |=> stage_ff[WIDTH-1:1] == $past(stage_ff[WIDTH-2:0]))
    else $error("Stages did not shift by one");

  chk_clock_shift: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_shift_ready ##0 s_clk_rise
      |=> stage_ff == shift_one($past(stage_ff), $past(ser_s)))
    else $error("Clock rise did not shift");

  chk_out_compl: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    loaded_ff |-> serial_out_n == !serial_out
      && serial_out == stage_ff[WIDTH-1])
    else $error("Outputs disagree with last stage");

  chk_inhibit_block: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sel_s && loaded_ff && inh_sy_ff[1] && $past(inh_sy_ff[1])
      |=> $stable(stage_ff))
    else $error("Shift while inhibit high");

  // Inhibit alone clocks the stages while the clock pin rests low
  chk_or_clock: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_shift_ready ##0 s_inh_rise |=> stage_ff[0] == $past(ser_s))
    else $error("Inhibit rise did not shift");

  // The bit leaving the last stage is what the receiver gets
  chk_buf_capture: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    shift_go && loaded_ff && buf_empty
      |=> out_valid && out_bit == $past(stage_ff[WIDTH-1]))
    else $error("Buffer missed the shifted-out bit");

  // A stalled receiver must see the same bit until it takes it
  chk_valid_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    out_valid && !out_ready && loaded_ff
      |=> out_valid && $stable(out_bit))
    else $error("Buffered bit changed before it was taken");

  chk_buf_count: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    buf_cnt_ff <= 2'(PLSR_BUF_DEPTH))
    else $error("Buffer count out of range");

  chk_pop_drain: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    buf_pop && !buf_push |=> buf_cnt_ff == $past(buf_cnt_ff) - 2'h1)
    else $error("Pop did not free a buffer entry");

  // Reset empties the buffer and drops the loaded mark
  chk_reset_clears: assert property (
    @(posedge ref_clk)
    !rst_n |=> !out_valid && !stages_valid)
    else $error("Reset left buffer or loaded mark set");
endmodule : plsr_shift_register
